// ### logic/iroc_irq_option_ctrl.sv
// interrupt enables, flags and option register with register port
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module iroc_irq_option_ctrl (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic [iroc_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [iroc_pkg::DATA_W-1:0] regWrData,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic      [iroc_pkg::DATA_W-1:0] regRdData,
  input  wire logic [iroc_pkg::PIN_N-1:0]  pinIn,
  input  wire logic                     timerExtClkPin,
  input  wire logic [7:0]               periphEvents,
  input  wire logic                     wdtBaseTick,
  input  wire logic                     wdtClear,
  output logic      [iroc_pkg::PIN_N-1:0]  pullupOn,
  output logic                          irqReq,
  output logic                          wdtTimeout
);
  import iroc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rstMeta_q;
  logic rstSync_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // submodules
  iroc_if link ();

  logic [7:0] option_q, option_d;
  logic [7:0] control_q, control_d;
  logic [7:0] periphEn_q, periphEn_d;
  logic [7:0] periphFlag_q, periphFlag_d;
  logic [5:0] pullupEn_q, pullupEn_d;
  logic [5:0] changeEn_q, changeEn_d;
  logic [7:0] t0Count_q, t0Count_d;
  logic [7:0] rdData_q, rdData_d;
  logic [5:0] pullup_q, pullup_d;
  logic       irq_q, irq_d;
  logic       wdto_q, wdto_d;

  assign link.t0SrcSel    = option_q[OPT_T0_SRC];
  assign link.t0SrcEdge   = option_q[OPT_T0_EDGE];
  assign link.prescAssign = option_q[OPT_ASSIGN];
  assign link.prescRate   = option_q[OPT_RATE_LSB +: 3];
  assign link.extEdgeSel  = option_q[OPT_EXT_EDGE];
  assign link.changeEn    = changeEn_q;
  assign link.pins        = pinIn;
  assign link.t0Pin       = timerExtClkPin;
  assign link.wdtBaseTick = wdtBaseTick;
  assign link.wdtClear    = wdtClear;

  iroc_prescaler #(
    .POST_W  (WDT_POST_W)
  ) u_presc (
    .clk_sys (clk_sys),
    .rst_b   (rstSync_q),
    .bus     (link.presc)
  );

  iroc_event_sense u_sense (
    .clk_sys (clk_sys),
    .rst_b   (rstSync_q),
    .bus     (link.sense)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file and flags
  always_comb begin
    logic wrOpt;
    logic wrCtl;
    logic wrPie;
    logic wrPir;
    logic wrT0;
    logic t0Ovf;
    logic coreAny;
    logic periphAny;
    wrOpt = regWr && (regAddr == OFS_OPTION);
    wrCtl = regWr && (regAddr == OFS_CONTROL);
    wrPie = regWr && (regAddr == OFS_PERIPH_EN);
    wrPir = regWr && (regAddr == OFS_PERIPH_FLAG);
    wrT0  = regWr && (regAddr == OFS_T0_COUNT);
    option_d   = wrOpt ? regWrData : option_q;
    periphEn_d = wrPie ? (regWrData & PERIPH_MASK) : periphEn_q;
    pullupEn_d = (regWr && regAddr == OFS_PULLUP_EN) ? (regWrData[5:0] & PULLUP_MASK)
                                                    : pullupEn_q;
    changeEn_d = (regWr && regAddr == OFS_CHANGE_EN) ? regWrData[5:0] : changeEn_q;
    // timer0 count
    t0Ovf     = link.t0Tick && (t0Count_q == 8'hff) && !wrT0;
    t0Count_d = wrT0 ? regWrData : (link.t0Tick ? t0Count_q + 8'h01 : t0Count_q);
    // flags: write first, then hardware sets on top
    control_d = wrCtl ? regWrData : control_q;
    if (t0Ovf) begin
      control_d[CTL_T0_FLAG] = 1'b1;
    end
    if (link.extEvent) begin
      control_d[CTL_EXT_FLAG] = 1'b1;
    end
    if (link.changeEvent) begin
      control_d[CTL_CHANGE_FLAG] = 1'b1;
    end
    periphFlag_d = (wrPir ? regWrData : periphFlag_q);
    periphFlag_d = (periphFlag_d | periphEvents) & PERIPH_MASK;
    // interrupt request from current state
    coreAny   = (control_q[CTL_T0_IE] & control_q[CTL_T0_FLAG])
              | (control_q[CTL_EXT_IE] & control_q[CTL_EXT_FLAG])
              | (control_q[CTL_CHANGE_IE] & control_q[CTL_CHANGE_FLAG]);
    periphAny = control_q[CTL_PERIPH_GATE] & (|(periphEn_q & periphFlag_q));
    irq_d     = control_q[CTL_GLOBAL_IE] & (coreAny | periphAny);
    wdto_d    = link.wdtTimeout;
    // read port
    rdData_d = 8'h00;
    if (regRd) begin
      case (regAddr)
        OFS_OPTION:      rdData_d = option_q;
        OFS_CONTROL:     rdData_d = control_q;
        OFS_PERIPH_EN:   rdData_d = periphEn_q;
        OFS_PERIPH_FLAG: rdData_d = periphFlag_q;
        OFS_PULLUP_EN:   rdData_d = {2'b00, pullupEn_q};
        OFS_CHANGE_EN:   rdData_d = {2'b00, changeEn_q};
        OFS_T0_COUNT:    rdData_d = t0Count_q;
        default:         rdData_d = 8'h00;
      endcase
    end
  end

  // per-pin pull-up drive
  for (genvar p = 0; p < PIN_N; p++) begin : g_pullup
    assign pullup_d[p] = ~option_q[OPT_PULLUP_DIS] & pullupEn_q[p];
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      option_q     <= RST_OPTION;
      control_q    <= RST_CONTROL;
      periphEn_q   <= RST_PERIPH;
      periphFlag_q <= RST_PERIPH;
      pullupEn_q   <= RST_PULLUP_EN;
      changeEn_q   <= RST_CHANGE_EN;
      rdData_q     <= 8'h00;
      pullup_q     <= 6'h00;
      irq_q        <= 1'b0;
      wdto_q       <= 1'b0;
    end else begin
      option_q     <= option_d;
      control_q    <= control_d;
      periphEn_q   <= periphEn_d;
      periphFlag_q <= periphFlag_d;
      pullupEn_q   <= pullupEn_d;
      changeEn_q   <= changeEn_d;
      rdData_q     <= rdData_d;
      pullup_q     <= pullup_d;
      irq_q        <= irq_d;
      wdto_q       <= wdto_d;
    end
  end

  // count survives reset
  always_ff @(posedge clk_sys) begin
    t0Count_q <= t0Count_d;
  end

  assign regRdData  = rdData_q;
  assign pullupOn   = pullup_q;
  assign irqReq     = irq_q;
  assign wdtTimeout = wdto_q;
endmodule // iroc_irq_option_ctrl

// ### common/iroc_pkg.sv
// constants for interrupt and option control block
//
// Contract
// - pull-up disable bit 1 turns all weak pull-ups off; 0 follows per-pin enables
// - external edge select: 1 rising edge, 0 falling edge raises external flag
// - timer0 source: 1 external clock pin transitions, 0 instruction clock
// - timer0 source edge: 1 counts falling, 0 counts rising pin transitions
// - prescaler assignment: 1 watchdog, 0 timer0; serves only one at a time
// - rate field divides timer0 by 2^(v+1), watchdog by 2^v
// - watchdog has its own dedicated 16-bit postscaler after the shared prescaler
// - every flag except pin-change sets on its event regardless of any enable bit; pin-change needs the pin's change enable
// - global enable 1 passes unmasked interrupts; 0 blocks all
// - peripheral gate must be 1 for any peripheral source to interrupt
// - control bit 5 timer0, bit 4 external pin, bit 3 pin-change enables
// - timer0 overflow flag bit 2 sets on rollover, held until cleared
// - timer0 count keeps its value through reset
// - external pin flag bit 1 sets on selected edge, held until cleared
// - pin-change flag bit 0 sets on change of any of pins 5..0 whose change enable is 1, held until cleared
// - peripheral enables bits 7..0 fixed layout, bit 4 unimplemented reads 0
// - peripheral flags share enable layout, bit 4 reads 0, cleared by software
package iroc_pkg;
  localparam int          ADDR_W          = 3;
  localparam int          DATA_W          = 8;
  localparam int          PIN_N           = 6;
  localparam logic [2:0]  OFS_OPTION      = 3'h0;
  localparam logic [2:0]  OFS_CONTROL     = 3'h1;
  localparam logic [2:0]  OFS_PERIPH_EN   = 3'h2;
  localparam logic [2:0]  OFS_PERIPH_FLAG = 3'h3;
  localparam logic [2:0]  OFS_PULLUP_EN   = 3'h4;
  localparam logic [2:0]  OFS_CHANGE_EN   = 3'h5;
  localparam logic [2:0]  OFS_T0_COUNT    = 3'h6;
  // option fields
  localparam int          OPT_PULLUP_DIS  = 7;
  localparam int          OPT_EXT_EDGE    = 6;
  localparam int          OPT_T0_SRC      = 5;
  localparam int          OPT_T0_EDGE     = 4;
  localparam int          OPT_ASSIGN      = 3;
  localparam int          OPT_RATE_LSB    = 0;
  // control fields
  localparam int          CTL_GLOBAL_IE   = 7;
  localparam int          CTL_PERIPH_GATE = 6;
  localparam int          CTL_T0_IE       = 5;
  localparam int          CTL_EXT_IE      = 4;
  localparam int          CTL_CHANGE_IE   = 3;
  localparam int          CTL_T0_FLAG     = 2;
  localparam int          CTL_EXT_FLAG    = 1;
  localparam int          CTL_CHANGE_FLAG = 0;
  // reset values and masks
  localparam logic [7:0]  RST_OPTION      = 8'hff;
  localparam logic [7:0]  RST_CONTROL     = 8'h00;
  localparam logic [7:0]  RST_PERIPH      = 8'h00;
  localparam logic [5:0]  RST_PULLUP_EN   = 6'h37;
  localparam logic [5:0]  RST_CHANGE_EN   = 6'h00;
  localparam logic [7:0]  PERIPH_MASK     = 8'hef;
  localparam logic [5:0]  PULLUP_MASK     = 6'h37;
  // timing
  localparam int          INSTR_DIV       = 4;
  localparam int          WDT_POST_W      = 16;
endpackage

// ### common/iroc_if.sv
// carrier between control core, prescaler and event sensing
`timescale 1ns/1ps
interface iroc_if;
  logic       t0SrcSel;
  logic       t0SrcEdge;
  logic       prescAssign;
  logic [2:0] prescRate;
  logic       extEdgeSel;
  logic [5:0] changeEn;
  logic [5:0] pins;
  logic       t0Pin;
  logic       wdtBaseTick;
  logic       wdtClear;
  logic       t0Tick;
  logic       wdtTimeout;
  logic       extEvent;
  logic       changeEvent;
  modport ctrl  (output t0SrcSel, t0SrcEdge, prescAssign, prescRate, extEdgeSel, changeEn,
                 pins, t0Pin, wdtBaseTick, wdtClear,
                 input t0Tick, wdtTimeout, extEvent, changeEvent);
  modport presc (input t0SrcSel, t0SrcEdge, prescAssign, prescRate, t0Pin, wdtBaseTick,
                 wdtClear, output t0Tick, wdtTimeout);
  modport sense (input extEdgeSel, changeEn, pins, output extEvent, changeEvent);
endinterface // iroc_if

// ### logic/iroc_prescaler.sv
// timer0 clock select, shared prescaler and watchdog postscaler
`timescale 1ns/1ps
module iroc_prescaler #(
  parameter int POST_W = 16
) (
  input  wire logic   clk_sys,
  input  wire logic   rst_b,
  iroc_if.presc       bus
);
  import iroc_pkg::*;

  if (POST_W < 1 || POST_W > 24) begin : g_chk
    $error("postscaler width out of range");
  end

  logic [1:0]        instrDiv_q, instrDiv_d;
  logic              pinPrev_q, pinPrev_d;
  logic [7:0]        presc_q, presc_d;
  logic [POST_W-1:0] post_q, post_d;
  logic              t0Tick_q, t0Tick_d;
  logic              wdto_q, wdto_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic       instrTick;
    logic       pinEdge;
    logic       t0Src;
    logic       wdtIn;
    logic       prescIn;
    logic       prescOut;
    logic [3:0] divExp;
    logic [7:0] mask;
    instrTick  = (instrDiv_q == 2'(INSTR_DIV - 1));
    instrDiv_d = instrDiv_q + 2'h1;
    pinPrev_d  = bus.t0Pin;
    pinEdge    = bus.t0SrcEdge ? (pinPrev_q & ~bus.t0Pin)
                               : (~pinPrev_q & bus.t0Pin);
    t0Src      = bus.t0SrcSel ? pinEdge : instrTick;
    wdtIn      = bus.wdtBaseTick;
    prescIn    = bus.prescAssign ? wdtIn : t0Src;
    divExp     = bus.prescAssign ? {1'b0, bus.prescRate}
                                 : {1'b0, bus.prescRate} + 4'h1;
    mask       = 8'((9'h001 << divExp) - 9'h001);
    prescOut   = prescIn & ((presc_q & mask) == mask);
    presc_d    = prescIn ? presc_q + 8'h01 : presc_q;
    t0Tick_d   = bus.prescAssign ? t0Src : prescOut;
    post_d     = post_q;
    wdto_d     = 1'b0;
    if (bus.wdtClear) begin
      post_d = '0;
      presc_d = bus.prescAssign ? 8'h00 : presc_d;
    end else if (bus.prescAssign ? prescOut : wdtIn) begin
      post_d = post_q + 1'b1;
      wdto_d = &post_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      instrDiv_q <= 2'h0;
      pinPrev_q  <= 1'b0;
      presc_q    <= 8'h00;
      post_q     <= '0;
      t0Tick_q   <= 1'b0;
      wdto_q     <= 1'b0;
    end else begin
      instrDiv_q <= instrDiv_d;
      pinPrev_q  <= pinPrev_d;
      presc_q    <= presc_d;
      post_q     <= post_d;
      t0Tick_q   <= t0Tick_d;
      wdto_q     <= wdto_d;
    end
  end

  assign bus.t0Tick     = t0Tick_q;
  assign bus.wdtTimeout = wdto_q;
endmodule // iroc_prescaler

// ### logic/iroc_event_sense.sv
// external pin edge and pin-change detection
`timescale 1ns/1ps
module iroc_event_sense (
  input  wire logic   clk_sys,
  input  wire logic   rst_b,
  iroc_if.sense       bus
);
  import iroc_pkg::*;

  logic [PIN_N-1:0] prev_q, prev_d;
  logic             primed_q, primed_d;
  logic             ext_q, ext_d;
  logic             chg_q, chg_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    prev_d   = bus.pins;
    primed_d = 1'b1;
    ext_d    = primed_q & (bus.extEdgeSel ? (~prev_q[2] & bus.pins[2])
                                          : (prev_q[2] & ~bus.pins[2]));
    chg_d    = primed_q & (|((prev_q ^ bus.pins) & bus.changeEn));
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev_q   <= '0;
      primed_q <= 1'b0;
      ext_q    <= 1'b0;
      chg_q    <= 1'b0;
    end else begin
      prev_q   <= prev_d;
      primed_q <= primed_d;
      ext_q    <= ext_d;
      chg_q    <= chg_d;
    end
  end

  assign bus.extEvent    = ext_q;
  assign bus.changeEvent = chg_q;
endmodule // iroc_event_sense

// ### testbench/iroc_ctrl_monitor.sv
// port assertions for the interrupt and option control block
`timescale 1ns/1ps
module iroc_ctrl_monitor (
  input wire logic                        clk_sys,
  input wire logic                        rst_b,
  input wire logic [iroc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [iroc_pkg::DATA_W-1:0] regWrData,
  input wire logic                        regWr,
  input wire logic                        regRd,
  input wire logic [iroc_pkg::DATA_W-1:0] regRdData,
  input wire logic [iroc_pkg::PIN_N-1:0]  pinIn,
  input wire logic [7:0]                  periphEvents,
  input wire logic [iroc_pkg::PIN_N-1:0]  pullupOn,
  input wire logic                        irqReq
);
  import iroc_pkg::*;
  logic [7:0] optQ, optD, ctlQ, ctlD, pieQ, pieD;
  logic [5:0] wpuQ, wpuD;
  ////////////////////////////////////////////////////////////////////////////
  // shadow of software writes
  always_comb begin
    optD = optQ;
    ctlD = ctlQ;
    pieD = pieQ;
    wpuD = wpuQ;
    if (regWr) begin
      case (regAddr)
        OFS_OPTION:    optD = regWrData;
        OFS_CONTROL:   ctlD = regWrData;
        OFS_PERIPH_EN: pieD = regWrData;
        OFS_PULLUP_EN: wpuD = regWrData[5:0];
        default:       optD = optQ;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      optQ <= RST_OPTION;
      ctlQ <= RST_CONTROL;
      pieQ <= RST_PERIPH;
      wpuQ <= RST_PULLUP_EN;
    end else begin
      optQ <= optD;
      ctlQ <= ctlD;
      pieQ <= pieD;
      wpuQ <= wpuD;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  pullup_off_a: assert property (optQ[7] && $past(optQ[7]) |-> pullupOn == 6'h00)
    else $error("pull-ups on while disabled");
  pullup_follow_a: assert property (!optQ[7] && !$past(optQ[7]) && wpuQ == $past(wpuQ)
    |-> pullupOn == (wpuQ & PULLUP_MASK)) else $error("pull-ups differ from enables");
  ext_edge_irq_a: assert property ((optQ[6] ? $rose(pinIn[2]) : $fell(pinIn[2]))
    && ctlQ[7] && ctlQ[4] |-> ##[1:4] irqReq) else $error("selected edge gave no request");
  global_block_a: assert property (!ctlQ[7] && !$past(ctlQ[7]) |-> !irqReq)
    else $error("request with global enable off");
  irq_needs_gie_a: assert property ($rose(irqReq) |-> $past(ctlQ[7]))
    else $error("request rose without global enable");
  enables_off_a: assert property (ctlQ[6:3] == 4'h0 && $past(ctlQ[6:3]) == 4'h0
    |-> !irqReq) else $error("request with all source enables off");
  periph_irq_a: assert property (periphEvents[0] && ctlQ[7] && ctlQ[6] && pieQ[0]
    |-> ##[1:3] irqReq) else $error("peripheral event gave no request");
  periph_bit4_a: assert property (regRd && (regAddr == OFS_PERIPH_EN ||
    regAddr == OFS_PERIPH_FLAG) |=> regRdData[4] == 1'b0) else $error("bit 4 reads one");
  ctl_readback_a: assert property (regRd && regAddr == OFS_CONTROL
    |=> regRdData[7:3] == ctlQ[7:3]) else $error("control enables read back wrong");
  irq_seen_c: cover property ($rose(irqReq));
  pullup_seen_c: cover property (pullupOn != 6'h00);
  ctl_read_c: cover property (regRd && regAddr == OFS_CONTROL);
endmodule // iroc_ctrl_monitor
bind iroc_irq_option_ctrl iroc_ctrl_monitor iroc_ctrl_monitor_i (.clk_sys(clk_sys),
  .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .pinIn(pinIn), .periphEvents(periphEvents), .pullupOn(pullupOn),
  .irqReq(irqReq));

// ### testbench/iroc_core_model.sv
// core side model counting interrupt requests
`timescale 1ns/1ps
module iroc_core_model (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic irqReq,
  output int        irqCount
);
  logic irqSeen;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irqSeen <= 1'b0;
      irqCount <= 0;
    end else begin
      irqSeen <= irqReq;
      if (irqReq && !irqSeen) begin
        irqCount <= irqCount + 1;
      end
    end
  end
endmodule // iroc_core_model

// ### testbench/iroc_irq_option_ctrl_tb.sv
// self-checking bench for the interrupt and option control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module iroc_irq_option_ctrl_tb;
  import iroc_pkg::*;
  typedef struct {logic [7:0] e; logic [7:0] m;} iroc_note_s;
  logic        clk_sys, rst_b, regWr, regRd, timerExtClkPin, rdSeen, irqReq;
  logic        wdtBaseTick, wdtClear, wdtTimeout;
  logic [2:0]  regAddr;
  logic [7:0]  regWrData, regRdData, periphEvents, rdVal, c0, v;
  logic [5:0]  pinIn, pullupOn;
  int          n_mismatch, checks, irqCount, n;
  iroc_note_s  notes[$];
  iroc_note_s  nt;
  logic [2:0]  rstAddr[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [7:0]  rstVal[7] = '{RST_OPTION, RST_CONTROL, RST_PERIPH, RST_PERIPH,
                             {2'h0, RST_PULLUP_EN}, {2'h0, RST_CHANGE_EN}, 8'h00};
  iroc_irq_option_ctrl iroc_irq_option_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .pinIn(pinIn), .timerExtClkPin(timerExtClkPin),
    .periphEvents(periphEvents), .wdtBaseTick(wdtBaseTick), .wdtClear(wdtClear),
    .pullupOn(pullupOn), .irqReq(irqReq), .wdtTimeout(wdtTimeout));
  iroc_core_model iroc_core_model_i (.clk_sys(clk_sys), .rst_b(rst_b), .irqReq(irqReq),
    .irqCount(irqCount));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    notes.push_back('{e, m});
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    rdVal = regRdData;
  endtask
  task automatic set_pins(input logic [5:0] p);
    @(posedge clk_sys);
    pinIn <= p;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) rdSeen <= regRd;
  always @(negedge clk_sys) begin
    if (rdSeen) begin
      nt = notes.pop_front();
      `CHK("read data", nt.e & nt.m, regRdData & nt.m)
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    stop_test();
  end
  initial begin
    {rst_b, regWr, regRd, timerExtClkPin, wdtBaseTick, wdtClear} = 6'h0;
    {regAddr, regWrData, pinIn, periphEvents} = '0;
    n_mismatch = 0;
    checks = 0;
    void'($urandom(32'h794b));
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    waitc(3);
    foreach (rstVal[i]) rd(rstAddr[i], rstVal[i], 8'hff);
    v = 8'($urandom);
    wr(OFS_OPTION, v);
    rd(OFS_OPTION, v, 8'hff);
    v = 8'($urandom);
    wr(OFS_PULLUP_EN, v);
    wr(OFS_OPTION, 8'h7f);
    waitc(3);
    `CHK("pull-ups", v[5:0] & PULLUP_MASK, pullupOn)
    wr(OFS_OPTION, 8'hff);
    waitc(3);
    `CHK("pull-ups off", 6'h00, pullupOn)
    wr(OFS_T0_COUNT, 8'h00);
    for (int r = 0; r < 5; r++) begin
      wr(OFS_OPTION, (r == 4) ? 8'h88 : 8'h80 | 8'(r));
      rd(OFS_T0_COUNT, 8'h00, 8'h00);
      c0 = rdVal;
      waitc(62);
      rd(OFS_T0_COUNT, 8'h00, 8'h00);
      `CHK("timer ticks", (r == 4) ? 8'h10 : 8'h08 >> r, 8'(rdVal - c0))
    end
    wr(OFS_OPTION, 8'h88);
    wr(OFS_T0_COUNT, 8'hfe);
    wr(OFS_CONTROL, 8'h00);
    waitc(16);
    rd(OFS_CONTROL, 8'h04, 8'h04);
    for (int e = 0; e < 2; e++) begin
      wr(OFS_OPTION, e ? 8'hb8 : 8'ha8);
      rd(OFS_T0_COUNT, 8'h00, 8'h00);
      c0 = rdVal;
      set_pins(6'h00);
      timerExtClkPin <= 1'b1;
      waitc(8);
      rd(OFS_T0_COUNT, 8'h00, 8'h00);
      `CHK("rise count", e ? 8'h00 : 8'h01, 8'(rdVal - c0))
      c0 = rdVal;
      @(posedge clk_sys) timerExtClkPin <= 1'b0;
      waitc(8);
      rd(OFS_T0_COUNT, 8'h00, 8'h00);
      `CHK("fall count", e ? 8'h01 : 8'h00, 8'(rdVal - c0))
    end
    rd(OFS_CONTROL, 8'h04, 8'h04);
    for (int e = 0; e < 2; e++) begin
      wr(OFS_OPTION, e ? 8'he8 : 8'ha8);
      set_pins(e ? 6'h04 : 6'h00);
      waitc(5);
      wr(OFS_CONTROL, 8'h00);
      set_pins(e ? 6'h00 : 6'h04);
      waitc(5);
      rd(OFS_CONTROL, 8'h00, 8'h02);
      wr(OFS_CONTROL, 8'h90);
      set_pins(e ? 6'h04 : 6'h00);
      waitc(5);
      `CHK("ext irq", 1'b1, irqReq)
      wr(OFS_CONTROL, 8'h12);
      waitc(3);
      `CHK("blocked irq", 1'b0, irqReq)
      rd(OFS_CONTROL, 8'h12, 8'hff);
      wr(OFS_CONTROL, 8'h00);
    end
    set_pins(6'h05);
    waitc(5);
    rd(OFS_CONTROL, 8'h00, 8'h01);
    wr(OFS_CHANGE_EN, 8'hff);
    rd(OFS_CHANGE_EN, 8'h3f, 8'hff);
    set_pins(6'h04);
    waitc(5);
    rd(OFS_CONTROL, 8'h01, 8'h01);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_PERIPH_EN, 8'hff);
    rd(OFS_PERIPH_EN, 8'hef, 8'hff);
    wr(OFS_PERIPH_FLAG, 8'hff);
    rd(OFS_PERIPH_FLAG, 8'hef, 8'hff);
    wr(OFS_PERIPH_FLAG, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_PERIPH_EN, 8'h01 << i);
      wr(OFS_CONTROL, 8'h80);
      @(posedge clk_sys) periphEvents <= 8'h01 << i;
      @(posedge clk_sys) periphEvents <= 8'h00;
      waitc(2);
      rd(OFS_PERIPH_FLAG, (i == 4) ? 8'h00 : 8'h01 << i, 8'hff);
      `CHK("gated irq", 1'b0, irqReq)
      wr(OFS_CONTROL, 8'hc0);
      waitc(3);
      `CHK("periph irq", 1'(i != 4), irqReq)
      wr(OFS_PERIPH_FLAG, 8'h00);
      waitc(3);
      `CHK("cleared irq", 1'b0, irqReq)
    end
    wr(OFS_PERIPH_EN, 8'h01);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= OFS_PERIPH_FLAG;
    regWrData <= 8'h00;
    periphEvents <= 8'h01;
    @(posedge clk_sys);
    regWr <= 1'b0;
    periphEvents <= 8'h00;
    rd(OFS_PERIPH_FLAG, 8'h01, 8'hff);
    waitc(3);
    `CHK("irq count", 10, irqCount)
    wr(OFS_T0_COUNT, 8'h5a);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    waitc(3);
    rd(OFS_T0_COUNT, 8'h5a, 8'hff);
    rd(OFS_PERIPH_FLAG, RST_PERIPH, 8'hff);
    wr(OFS_OPTION, 8'h88);
    @(posedge clk_sys);
    wdtClear <= 1'b1;
    @(posedge clk_sys);
    wdtClear <= 1'b0;
    wdtBaseTick <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (wdtTimeout !== 1'b1 && n < 70000);
    `CHK("wdt cycles", (1 << WDT_POST_W) + 2, n)
    @(negedge clk_sys);
    `CHK("wdt pulse", 1'b0, wdtTimeout)
    stop_test();
  end
endmodule // iroc_irq_option_ctrl_tb
